// ### inc/hbre_pkg.sv
// constants and helpers for the processor bus retry and error block
package hbre_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int BUS_TIMEOUT_NS = 25600;
  localparam int BUS_TIMEOUT_CYC = (BUS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] TMR_LOAD = 9'(BUS_TIMEOUT_CYC);
  // register offsets
  localparam logic [7:0] OFS_CHIP_CTRL = 8'h00;
  localparam logic [7:0] OFS_ARB_CTRL = 8'h04;
  localparam logic [7:0] OFS_SYS_ERR_STAT = 8'h08;
  localparam logic [7:0] OFS_SYS_ERR_ADDR = 8'h0c;
  localparam logic [7:0] OFS_MEM_ERR_STAT = 8'h10;
  localparam logic [7:0] OFS_MEM_ERR_ADDR = 8'h14;
  localparam logic [7:0] OFS_LINK_STAT = 8'h18;
  localparam logic [7:0] OFS_PCI_STAT = 8'h1c;
  // reset values
  localparam logic [31:0] CHIP_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ARB_CTRL_RST = 32'h0000_0000;
  // global chip control bits
  localparam int CTL_APAR_EN = 0;
  localparam int CTL_DPAR_EN = 1;
  localparam int CTL_ADDR_CHK_EN = 2;
  localparam int CTL_TIMER_EN = 3;
  localparam int CTL_ECC_DIAG = 4;
  localparam int CTL_SBE_REPORT = 17;
  localparam int CTL_LOCK_EN = 24;
  localparam int CTL_MCHK_MODE = 26;
  // arbiter control bits
  localparam int ARB_EIEIO_RETRY = 10;
  // system error status bits
  localparam int SES_NOSEL = 0;
  localparam int SES_TIMEOUT = 1;
  localparam int SES_CHECKSTOP_OUT = 2;
  localparam int SES_APAR = 3;
  localparam int SES_DPAR = 4;
  localparam int SES_MEM = 5;
  localparam int SES_PCI = 6;
  // memory error status bits
  localparam int MES_SBE = 0;
  localparam int MES_DBE = 1;
  localparam int MES_SYN_LSB = 8;
  // link status: per bridge field, pci64 above pci32
  localparam int LNK_DEV_ERR = 0;
  localparam int LNK_SERR = 1;
  localparam int LNK_STRIDE = 4;
  // pci status: pci32 low half, pci64 high half
  localparam int PCI_MABORT = 13;
  localparam int PCI_STRIDE = 16;
  // bus encodings
  localparam logic [4:0] TT_SYNC = 5'h08;
  localparam logic [4:0] TT_EIEIO = 5'h10;
  localparam logic [2:0] MAX_OUTSTANDING = 3'h2;
  localparam logic [3:0] FULL_BEAT_BYTES = 4'h8;
  localparam logic [31:0] NODEV_DATA = 32'hffff_ffff;
  // access targets from the address decoder
  localparam logic [2:0] TGT_MEM = 3'h0;
  localparam logic [2:0] TGT_PCI32 = 3'h1;
  localparam logic [2:0] TGT_PCI64 = 3'h2;
  localparam logic [2:0] TGT_INT = 3'h3;
  localparam logic [2:0] TGT_CFG = 3'h4;
  localparam logic [2:0] TGT_EXT = 3'h5;

  // transfer types that move data; everything else is address-only
  function automatic logic is_data_op(input logic [4:0] tt);
    case (tt)
      5'h02, 5'h06, 5'h0a, 5'h0b, 5'h0e, 5'h12, 5'h14, 5'h1a, 5'h1c, 5'h1e: is_data_op = 1'b1;
      default: is_data_op = 1'b0;
    endcase
  endfunction
endpackage

// ### src/hbre_sync2.sv
// two flop synchroniser for a pin level
`timescale 1ns/10ps
`default_nettype none
module hbre_sync2 (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // level
  input wire logic din,
  output logic dout
);
  logic meta_reg;

  // resets to the inactive high level of the pin
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule // hbre_sync2
`default_nettype wire

// ### src/hbre_retry_pins.sv
// retry and shared snoop pin drivers with precharge
`timescale 1ns/10ps
`default_nettype none
module hbre_retry_pins (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // window control
  input wire logic win_start,
  input wire logic retry_req,
  // open drain pins
  output logic addr_retry_n_out,
  output logic addr_retry_n_oe,
  output logic shared_snoop_n_out,
  output logic shared_snoop_n_oe
);
  logic d1_reg;
  logic d2_reg;
  logic pre_next;
  logic drive_low_next;

  // window is the cycle after addr_ack; precharge two cycles after it
  assign drive_low_next = win_start & retry_req;
  assign pre_next = d2_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      d1_reg <= 1'b0;
      d2_reg <= 1'b0;
      addr_retry_n_out <= 1'b1;
      addr_retry_n_oe <= 1'b0;
      shared_snoop_n_out <= 1'b1;
      shared_snoop_n_oe <= 1'b0;
    end else begin
      d1_reg <= win_start;
      d2_reg <= d1_reg;
      // precharge after every window, whoever pulled the lines low
      addr_retry_n_out <= !drive_low_next;
      addr_retry_n_oe <= drive_low_next | pre_next;
      shared_snoop_n_out <= 1'b1;
      shared_snoop_n_oe <= pre_next;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_window;
    win_start ##1 1'b1;
  endsequence
  sequence s_precharge;
    addr_retry_n_oe && addr_retry_n_out && shared_snoop_n_oe && shared_snoop_n_out;
  endsequence
  property p_precharge;
    s_window |=> ##1 s_precharge;
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge missing after retry window");
  property p_retry_drive;
    win_start && retry_req |=> addr_retry_n_oe && !addr_retry_n_out ##1 !addr_retry_n_oe || addr_retry_n_out;
  endproperty
  a_retry_drive: assert property (p_retry_drive) else $error("retry not driven in window");
endmodule // hbre_retry_pins
`default_nettype wire

// ### src/hbre_top.sv
// processor bus retry, lock, config and error response logic
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module hbre_top
  import hbre_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // address tenure from the bus front end
  input wire logic ts_valid,
  input wire logic [31:0] ts_addr,
  input wire logic [4:0] ts_type,
  input wire logic ts_cpu,
  input wire logic ts_read,
  input wire logic [3:0] ts_nbytes,
  input wire logic [2:0] ts_tgt,
  input wire logic deadlock_hit,
  input wire logic lock_range_hit,
  input wire logic addr_ack,
  input wire logic slave_claim,
  input wire logic first_ta,
  // ordering and conflict status from the units
  input wire logic [1:0] store_buf_empty,
  input wire logic [1:0] reads_done,
  input wire logic [1:0] data_buffered,
  input wire logic [2:0] outstanding,
  input wire logic [1:0] isa_req,
  input wire logic dma_line_match,
  // lock release pin
  input wire logic lock_release_n,
  // unit completion and error reports
  input wire logic unit_done,
  input wire logic ecc_single,
  input wire logic ecc_double,
  input wire logic [7:0] ecc_syndrome,
  input wire logic pci_no_devsel,
  input wire logic pci_serr,
  input wire logic int_bad,
  input wire logic addr_par_err,
  input wire logic data_par_err,
  // processor responses
  output logic transfer_ack,
  output logic transfer_error_ack,
  output logic [31:0] resp_data,
  output logic [1:0] machine_check_out,
  output logic checkstop_out,
  output logic lock_out,
  // open drain bus pins
  output logic addr_retry_n_out,
  output logic addr_retry_n_oe,
  output logic shared_snoop_n_out,
  output logic shared_snoop_n_oe
);
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_WIN, ST_DATA} hbre_state_t;

  hbre_state_t state_reg, state_next;
  logic [31:0] ctrl_reg, arb_reg, sea_reg, mea_reg, pst_reg;
  logic [7:0] ses_reg, lnk_reg;
  logic [15:0] mes_reg;
  logic [31:0] tn_addr_reg;
  logic [4:0] tn_tt_reg;
  logic tn_cpu_reg, tn_read_reg, tn_dl_reg, tn_lrh_reg;
  logic [3:0] tn_nbytes_reg;
  logic [2:0] tn_tgt_reg;
  logic retry_reg, claim_reg;
  logic [8:0] tmr_reg;
  logic lock_rel_s;

  function automatic logic wr_hit(input logic [7:0] a, input logic w, input logic [7:0] ofs);
    wr_hit = w && (a == ofs);
  endfunction

  hbre_sync2 u_lock_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .din(lock_release_n),
    .dout(lock_rel_s)
  );

  // tenure decode
  wire is_pci = (tn_tgt_reg == TGT_PCI32) || (tn_tgt_reg == TGT_PCI64);
  wire is_p64 = tn_tgt_reg == TGT_PCI64;
  wire is_mem = tn_tgt_reg == TGT_MEM;
  wire is_bus_slave = (tn_tgt_reg == TGT_CFG) || (tn_tgt_reg == TGT_EXT);
  wire win_start = (state_reg == ST_ADDR) && addr_ack;
  wire sync_ok = store_buf_empty[tn_cpu_reg] && reads_done[tn_cpu_reg] && data_buffered[tn_cpu_reg];

  // retry causes, evaluated on addr_ack
  wire r_sync = (tn_tt_reg == TT_SYNC) && !sync_ok;
  wire r_eieio = (tn_tt_reg == TT_EIEIO) && arb_reg[ARB_EIEIO_RETRY] && !sync_ok;
  wire r_xfer = is_data_op(tn_tt_reg) && (outstanding > MAX_OUTSTANDING);
  wire r_isa = ((tn_tgt_reg == TGT_PCI32) && isa_req[0]) || (is_p64 && isa_req[1]);
  wire r_dma = is_mem && dma_line_match;
  wire r_dl = is_pci && tn_dl_reg;
  // lock_out drops one cycle after release, so the retry keys on release alone
  wire r_lock = is_pci && ctrl_reg[CTL_LOCK_EN] && !lock_rel_s && tn_lrh_reg;
  wire retry_now = r_sync || r_eieio || r_xfer || r_isa || r_dma || r_dl || r_lock;
  wire lock_set = win_start && !retry_now && is_pci && lock_rel_s && tn_lrh_reg && ctrl_reg[CTL_LOCK_EN];

  hbre_retry_pins u_pins (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .win_start(win_start),
    .retry_req(retry_now),
    .addr_retry_n_out(addr_retry_n_out),
    .addr_retry_n_oe(addr_retry_n_oe),
    .shared_snoop_n_out(shared_snoop_n_out),
    .shared_snoop_n_oe(shared_snoop_n_oe)
  );

  // completion and error classification
  wire done_in = is_bus_slave ? first_ta : unit_done;
  wire fin_data = (state_reg == ST_DATA) && done_in;
  wire ev_noclaim = (state_reg == ST_WIN) && !retry_reg && is_bus_slave && !(claim_reg || slave_claim);
  wire ev_timeout = (state_reg == ST_DATA) && !done_in && ctrl_reg[CTL_TIMER_EN] && (tmr_reg == 9'h000);
  wire apar = addr_par_err && ctrl_reg[CTL_APAR_EN];
  wire dpar = data_par_err && ctrl_reg[CTL_DPAR_EN];
  wire mode26 = ctrl_reg[CTL_MCHK_MODE];
  wire e_sbe = fin_data && is_mem && ecc_single && !ecc_double;
  wire e_dbe = fin_data && is_mem && ecc_double;
  wire e_dbe_diag = e_dbe && ctrl_reg[CTL_ECC_DIAG];
  wire e_dbe_norm = e_dbe && !ctrl_reg[CTL_ECC_DIAG];
  wire e_mabort = fin_data && is_pci && pci_no_devsel;
  wire e_serr = fin_data && is_pci && pci_serr && !pci_no_devsel;
  wire e_nosel = ev_noclaim && (tn_tgt_reg == TGT_EXT) && ctrl_reg[CTL_ADDR_CHK_EN];
  wire e_cfg_abs = ev_noclaim && (tn_tgt_reg == TGT_CFG);
  wire sbe_report = e_sbe && ctrl_reg[CTL_SBE_REPORT] && mode26;
  wire mc_class = e_dbe_norm || e_mabort || e_serr || e_nosel;
  // no-select takes tea for stores too; the others only for loads
  wire tea_fire = mc_class && !mode26 && (tn_read_reg || e_nosel);
  wire short_wr = !tn_read_reg && (tn_nbytes_reg < FULL_BEAT_BYTES);
  wire mc_fire = (mc_class && !tea_fire) || sbe_report || (e_dbe_diag && short_wr);
  // bad internal accesses end like good ones, reads give zero
  wire ta_fire = ((fin_data && !is_bus_slave) || ev_timeout || ev_noclaim) && !tea_fire;
  wire [31:0] resp_data_next = e_cfg_abs ? NODEV_DATA : 32'h0000_0000;

  // status set terms
  wire [7:0] ses_set = {1'b0, e_mabort || e_serr, sbe_report || e_dbe_norm, dpar, apar,
                        ev_timeout || apar || dpar, ev_timeout, e_nosel};
  wire sea_cap = e_nosel || ev_timeout || sbe_report || e_dbe_norm || e_mabort || e_serr;
  wire mea_cap = e_sbe || e_dbe;
  wire [15:0] mes_set = {8'h00, 6'h00, e_dbe, e_sbe};
  wire [7:0] lnk_set = 8'({e_serr, e_mabort}) << (is_p64 ? LNK_STRIDE : 0);
  wire [31:0] pst_set = 32'(e_mabort || e_serr) << (PCI_MABORT + (is_p64 ? PCI_STRIDE : 0));
  wire ses_clr_wr = wr_hit(reg_addr, reg_wr, OFS_SYS_ERR_STAT);
  wire mes_clr_wr = wr_hit(reg_addr, reg_wr, OFS_MEM_ERR_STAT);

  // register read mux
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      OFS_CHIP_CTRL: rd_mux = ctrl_reg;
      OFS_ARB_CTRL: rd_mux = arb_reg;
      OFS_SYS_ERR_STAT: rd_mux = {24'h000000, ses_reg};
      OFS_SYS_ERR_ADDR: rd_mux = sea_reg;
      OFS_MEM_ERR_STAT: rd_mux = {16'h0000, mes_reg};
      OFS_MEM_ERR_ADDR: rd_mux = mea_reg;
      OFS_LINK_STAT: rd_mux = {24'h000000, lnk_reg};
      OFS_PCI_STAT: rd_mux = pst_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    case (state_reg)
      ST_IDLE: state_next = ts_valid ? ST_ADDR : ST_IDLE;
      ST_ADDR: state_next = addr_ack ? ST_WIN : ST_ADDR;
      ST_WIN: state_next = (retry_reg || ev_noclaim) ? ST_IDLE : ST_DATA;
      ST_DATA: state_next = (done_in || ev_timeout) ? ST_IDLE : ST_DATA;
      default: state_next = ST_IDLE;
    endcase
  end

  // tenure capture and sequencing
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      tn_addr_reg <= 32'h0000_0000;
      tn_tt_reg <= 5'h00;
      tn_cpu_reg <= 1'b0;
      tn_read_reg <= 1'b0;
      tn_nbytes_reg <= 4'h0;
      tn_tgt_reg <= TGT_MEM;
      tn_dl_reg <= 1'b0;
      tn_lrh_reg <= 1'b0;
      retry_reg <= 1'b0;
      claim_reg <= 1'b0;
      tmr_reg <= TMR_LOAD;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && ts_valid) begin
        tn_addr_reg <= ts_addr;
        tn_tt_reg <= ts_type;
        tn_cpu_reg <= ts_cpu;
        tn_read_reg <= ts_read;
        tn_nbytes_reg <= ts_nbytes;
        tn_tgt_reg <= ts_tgt;
        tn_dl_reg <= deadlock_hit;
        tn_lrh_reg <= lock_range_hit;
      end
      if (win_start) begin
        retry_reg <= retry_now;
      end
      claim_reg <= (state_reg == ST_ADDR || state_reg == ST_WIN) && (claim_reg || slave_claim);
      // timer inhibited while disabled
      if (win_start || !ctrl_reg[CTL_TIMER_EN]) begin
        tmr_reg <= TMR_LOAD;
      end else if (state_reg == ST_DATA && tmr_reg != 9'h000) begin
        tmr_reg <= tmr_reg - 9'h001;
      end
    end
  end

  // software registers; hardware set wins over write-one-to-clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= CHIP_CTRL_RST;
      arb_reg <= ARB_CTRL_RST;
      ses_reg <= 8'h00;
      mes_reg <= 16'h0000;
      lnk_reg <= 8'h00;
      pst_reg <= 32'h0000_0000;
      sea_reg <= 32'h0000_0000;
      mea_reg <= 32'h0000_0000;
      reg_rdata <= 32'h0000_0000;
    end else begin
      if (wr_hit(reg_addr, reg_wr, OFS_CHIP_CTRL)) ctrl_reg <= reg_wdata;
      if (wr_hit(reg_addr, reg_wr, OFS_ARB_CTRL)) arb_reg <= reg_wdata;
      ses_reg <= (ses_reg & ~(ses_clr_wr ? reg_wdata[7:0] : 8'h00)) | ses_set;
      mes_reg <= (mes_reg & ~(mes_clr_wr ? reg_wdata[15:0] : 16'h0000)) | mes_set;
      lnk_reg <= (lnk_reg & ~(wr_hit(reg_addr, reg_wr, OFS_LINK_STAT) ? reg_wdata[7:0] : 8'h00)) | lnk_set;
      pst_reg <= (pst_reg & ~(wr_hit(reg_addr, reg_wr, OFS_PCI_STAT) ? reg_wdata : 32'h0000_0000)) | pst_set;
      // only the first error since the last clear is captured
      if (sea_cap && ses_reg == 8'h00) sea_reg <= tn_addr_reg;
      if (mea_cap && mes_reg == 16'h0000) begin
        mea_reg <= tn_addr_reg;
        if (e_sbe) mes_reg[MES_SYN_LSB +: 8] <= ecc_syndrome;
      end
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // processor side outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      transfer_ack <= 1'b0;
      transfer_error_ack <= 1'b0;
      resp_data <= 32'h0000_0000;
      machine_check_out <= 2'b00;
      checkstop_out <= 1'b0;
      lock_out <= 1'b0;
    end else begin
      transfer_ack <= ta_fire;
      transfer_error_ack <= tea_fire;
      resp_data <= ta_fire ? resp_data_next : 32'h0000_0000;
      machine_check_out <= mc_fire ? {tn_cpu_reg, !tn_cpu_reg} : 2'b00;
      // only reset ends a checkstop
      checkstop_out <= checkstop_out || apar || dpar || ev_timeout;
      lock_out <= lock_set || (lock_out && lock_rel_s);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_chk_sticky;
    checkstop_out |=> checkstop_out;
  endproperty
  a_chk_sticky: assert property (p_chk_sticky) else $error("checkstop dropped before reset");
  property p_timeout;
    ev_timeout |=> checkstop_out && transfer_ack && ses_reg[SES_TIMEOUT] && ses_reg[SES_CHECKSTOP_OUT];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout response wrong");
  property p_mc_one;
    $onehot0(machine_check_out);
  endproperty
  a_mc_one: assert property (p_mc_one) else $error("machine check to both cpus");
  property p_cfg_absent;
    e_cfg_abs |=> transfer_ack && (resp_data == NODEV_DATA) && !transfer_error_ack;
  endproperty
  a_cfg_absent: assert property (p_cfg_absent) else $error("absent unit not acked with no-device data");
  property p_tea_mode;
    transfer_error_ack |-> !$past(mode26) && !transfer_ack;
  endproperty
  a_tea_mode: assert property (p_tea_mode) else $error("tea with machine check mode set");
  property p_lock_cond;
    $rose(lock_out) |-> $past(lock_rel_s && ctrl_reg[CTL_LOCK_EN] && tn_lrh_reg);
  endproperty
  a_lock_cond: assert property (p_lock_cond) else $error("lock raised without its conditions");
  sequence s_sync_block;
    win_start && (tn_tt_reg == TT_SYNC) && !sync_ok;
  endsequence
  property p_sync_retry;
    s_sync_block |=> addr_retry_n_oe && !addr_retry_n_out ##1 state_reg == ST_IDLE;
  endproperty
  a_sync_retry: assert property (p_sync_retry) else $error("sync not retried");
  property p_xfer_retry;
    win_start && is_data_op(tn_tt_reg) && (outstanding > MAX_OUTSTANDING) |=> !addr_retry_n_out;
  endproperty
  a_xfer_retry: assert property (p_xfer_retry) else $error("transfer not retried when busy");
  property p_sea_hold;
    (ses_reg != 8'h00) && !ses_clr_wr |=> $stable(sea_reg);
  endproperty
  a_sea_hold: assert property (p_sea_hold) else $error("error address overwritten");
  property p_nosel;
    e_nosel |=> ses_reg[SES_NOSEL] && (transfer_error_ack || machine_check_out != 2'b00);
  endproperty
  a_nosel: assert property (p_nosel) else $error("no-select not reported");
endmodule // hbre_top
`default_nettype wire

// ### dv/hbre_cpu_model.sv
// processor side of the bus: pull-ups on the shared pins and request back-off
`timescale 1ns/10ps
`default_nettype none
module hbre_cpu_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // pins as driven by the block
  input wire logic addr_retry_n_out,
  input wire logic addr_retry_n_oe,
  input wire logic shared_snoop_n_out,
  input wire logic shared_snoop_n_oe,
  // resolved wires and request
  output logic addr_retry_n,
  output logic shared_snoop_n,
  output logic bus_request_n
);
  // cpus never precharge, so only the pull-up holds a released line high
  assign addr_retry_n = addr_retry_n_oe ? addr_retry_n_out : 1'b1;
  assign shared_snoop_n = shared_snoop_n_oe ? shared_snoop_n_out : 1'b1;
  // retried master backs off one cycle so the retrier wins arbitration
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bus_request_n <= 1'b1;
    end else begin
      bus_request_n <= ~addr_retry_n;
    end
  end
endmodule // hbre_cpu_model
`default_nettype wire

// ### dv/hbre_top_bench.sv
// self-checking bench for the processor bus retry and error block
`timescale 1ns/10ps
`default_nettype none
module hbre_top_bench
  import hbre_pkg::*;
;
  logic sys_clk, nrst, reg_wr, reg_rd, ts_valid, ts_cpu, ts_read, deadlock_hit, lock_range_hit, addr_ack;
  logic slave_claim, first_ta, dma_line_match, lock_release_n, unit_done, ecc_single, ecc_double;
  logic pci_no_devsel, pci_serr, int_bad, addr_par_err, data_par_err, transfer_ack, transfer_error_ack;
  logic checkstop_out, lock_out, addr_retry_n_out, addr_retry_n_oe, shared_snoop_n_out, shared_snoop_n_oe;
  logic addr_retry_n, shared_snoop_n, bus_request_n;
  logic [7:0] reg_addr, ecc_syndrome;
  logic [31:0] reg_wdata, reg_rdata, ts_addr, resp_data, d;
  logic [4:0] ts_type;
  logic [3:0] ts_nbytes;
  logic [2:0] ts_tgt, outstanding;
  logic [1:0] store_buf_empty, reads_done, data_buffered, isa_req, machine_check_out;
  int miscompares, n_checks, cyc;

  hbre_top i_hbre_top (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ts_valid, .ts_addr, .ts_type,
    .ts_cpu, .ts_read, .ts_nbytes, .ts_tgt, .deadlock_hit, .lock_range_hit, .addr_ack, .slave_claim, .first_ta,
    .store_buf_empty, .reads_done, .data_buffered, .outstanding, .isa_req, .dma_line_match, .lock_release_n, .unit_done,
    .ecc_single, .ecc_double, .ecc_syndrome, .pci_no_devsel, .pci_serr, .int_bad, .addr_par_err, .data_par_err,
    .transfer_ack, .transfer_error_ack, .resp_data, .machine_check_out, .checkstop_out, .lock_out, .addr_retry_n_out,
    .addr_retry_n_oe, .shared_snoop_n_out, .shared_snoop_n_oe);
  hbre_cpu_model i_hbre_cpu_model (.sys_clk, .nrst, .addr_retry_n_out, .addr_retry_n_oe, .shared_snoop_n_out,
    .shared_snoop_n_oe, .addr_retry_n, .shared_snoop_n, .bus_request_n);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // hang guard, well above the 150 or so cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  // returns just after the edge that samples addr_ack
  task automatic tenure(input logic [4:0] tt, input logic [2:0] tgt, input logic rdn, input logic cpu);
    @(posedge sys_clk);
    ts_valid <= 1'b1;
    ts_type <= tt;
    ts_tgt <= tgt;
    ts_read <= rdn;
    ts_cpu <= cpu;
    @(posedge sys_clk);
    ts_valid <= 1'b0;
    addr_ack <= 1'b1;
    @(posedge sys_clk);
    addr_ack <= 1'b0;
  endtask

  task automatic unit_end(input logic dbl);
    @(posedge sys_clk);
    unit_done <= 1'b1;
    ecc_double <= dbl;
    @(posedge sys_clk);
    unit_done <= 1'b0;
    ecc_double <= 1'b0;
  endtask

  task automatic wait_resp;
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (transfer_ack !== 1'b1 && transfer_error_ack !== 1'b1 && machine_check_out === 2'b00 && n < 300);
    if (n == 300) chk(32'h0, 32'h1);
  endtask

  task automatic t_regs;
    rd(OFS_CHIP_CTRL);
    chk(d, CHIP_CTRL_RST);
    rd(OFS_ARB_CTRL);
    chk(d, ARB_CTRL_RST);
    rd(8'hf0);
    chk(d, 32'h0);
    chk(checkstop_out, 1'b0);
  endtask

  // one retry cause per pass; pass 5 is eieio with the eieio retry bit still clear
  task automatic t_retry;
    for (int i = 0; i < 7; i++) begin
      if (i == 6) wr(OFS_ARB_CTRL, 32'h1 << ARB_EIEIO_RETRY);
      @(posedge sys_clk);
      outstanding <= (i == 0) ? 3'h3 : 3'h0;
      isa_req <= (i == 1) ? 2'b01 : 2'b00;
      dma_line_match <= (i == 2);
      deadlock_hit <= (i == 3);
      store_buf_empty <= (i > 3) ? 2'b10 : 2'b11;
      tenure((i > 4) ? TT_EIEIO : (i == 4) ? TT_SYNC : 5'h0a, (i == 1) ? TGT_PCI32 : (i == 3) ? TGT_PCI64 : TGT_MEM,
        1'b1, 1'b0);
      @(negedge sys_clk);
      chk({addr_retry_n_oe, addr_retry_n}, (i == 5) ? 2'b01 : 2'b10);
      @(negedge sys_clk);
      chk(bus_request_n, i != 5);
      @(negedge sys_clk);
      chk({addr_retry_n_oe, addr_retry_n_out, shared_snoop_n_oe, shared_snoop_n_out}, 4'hf);
      // unretried eieio sits in the data phase until the unit finishes
      if (i == 5) begin
        unit_end(1'b0);
        wait_resp();
        chk(transfer_ack, 1'b1);
      end
      repeat (4) @(posedge sys_clk);
    end
    store_buf_empty <= 2'b11;
  endtask

  task automatic t_config;
    ts_nbytes <= 4'h4;
    tenure(5'h0a, TGT_CFG, 1'b1, 1'b0);
    wait_resp();
    chk(transfer_ack, 1'b1);
    chk(resp_data, NODEV_DATA);
    tenure(5'h0a, TGT_INT, 1'b1, 1'b0);
    unit_end(1'b0);
    wait_resp();
    chk(transfer_ack, 1'b1);
    chk(resp_data, 32'h0);
    ts_nbytes <= FULL_BEAT_BYTES;
  endtask

  task automatic t_lock;
    wr(OFS_CHIP_CTRL, 32'h1 << CTL_LOCK_EN);
    lock_range_hit <= 1'b1;
    tenure(5'h0a, TGT_PCI32, 1'b1, 1'b0);
    unit_end(1'b0);
    wait_resp();
    chk(lock_out, 1'b1);
    @(posedge sys_clk);
    lock_release_n <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(lock_out, 1'b0);
    tenure(5'h0a, TGT_PCI32, 1'b1, 1'b0);
    @(negedge sys_clk);
    chk({addr_retry_n_oe, addr_retry_n}, 2'b10);
    repeat (3) @(posedge sys_clk);
    lock_release_n <= 1'b1;
    lock_range_hit <= 1'b0;
  endtask

  task automatic t_ecc;
    @(posedge sys_clk);
    ts_addr <= 32'h0000_1040;
    tenure(5'h0a, TGT_MEM, 1'b1, 1'b0);
    unit_end(1'b1);
    wait_resp();
    chk({transfer_error_ack, machine_check_out}, 3'b100);
    rd(OFS_MEM_ERR_STAT);
    chk(d[1:0], 2'b10);
    rd(OFS_SYS_ERR_STAT);
    chk(d, 32'h1 << SES_MEM);
    @(posedge sys_clk);
    ts_addr <= 32'h0000_2080;
    tenure(5'h02, TGT_MEM, 1'b0, 1'b1);
    unit_end(1'b1);
    wait_resp();
    chk(machine_check_out, 2'b10);
    rd(OFS_MEM_ERR_ADDR);
    chk(d, 32'h0000_1040);
  endtask

  // last on purpose: checkstop cannot be undone short of reset
  task automatic t_checkstop;
    wr(OFS_CHIP_CTRL, 32'h1 << CTL_APAR_EN);
    @(posedge sys_clk);
    addr_par_err <= 1'b1;
    @(posedge sys_clk);
    addr_par_err <= 1'b0;
    rd(OFS_SYS_ERR_STAT);
    chk(d[SES_APAR], 1'b1);
    wr(OFS_SYS_ERR_STAT, 32'hffff_ffff);
    repeat (3) @(negedge sys_clk);
    chk(checkstop_out, 1'b1);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(checkstop_out, 1'b0);
    nrst <= 1'b1;
  endtask

  initial begin
    {reg_wr, reg_rd, ts_valid, ts_cpu, ts_read, deadlock_hit, lock_range_hit, addr_ack, slave_claim, first_ta} = '0;
    {dma_line_match, unit_done, ecc_single, ecc_double, pci_no_devsel, pci_serr, int_bad, addr_par_err} = '0;
    {data_par_err, reg_addr, ecc_syndrome, reg_wdata, ts_addr, ts_type, ts_tgt, outstanding, isa_req} = '0;
    {store_buf_empty, reads_done, data_buffered} = '1;
    ts_nbytes = FULL_BEAT_BYTES;
    lock_release_n = 1'b1;
    nrst = 1'b0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_regs();
    t_retry();
    t_config();
    t_ecc();
    t_lock();
    t_checkstop();
    print_verdict();
  end
endmodule // hbre_top_bench
`default_nettype wire
